// ==== core/sacsr_host.sv ====
// host end: trigger, shift clock generation and result capture
`timescale 1ns/1ps
module sacsr_host
  import sacsr_pkg::*;
#(
  parameter int PowerOnWait = sacsr_pkg::POR_WAIT_CYCLES,
  parameter int WakeWait    = sacsr_pkg::WAKE_DELAY_CYCLES
)(
  // clock and reset
  input  wire logic                          clk,
  input  wire logic                          sys_rst,
  // link
  sacsr_link_if.host                         link,
  // user side
  input  wire logic                          startReq,
  input  wire logic                          sleepReq,
  input  wire logic                          chainSel,
  input  wire logic [4:0]                    readBits,
  output logic                               ready,
  output logic                               resultValid,
  output logic [31:0]                        resultData
);
  import sacsr_pkg::*;

  typedef enum logic [2:0] {
    H_POR, H_IDLE, H_TRIG, H_WAIT, H_SHIFT, H_ACQ, H_WAKE
  } sacsr_host_state_type;

  sacsr_host_state_type state_reg;
  logic [31:0]          cnt_reg;
  logic [BIT_CNT_W-1:0] bits_reg;
  logic                 sck_reg;
  logic                 cnv_reg;
  logic                 second_reg;
  logic                 slept_reg;
  logic [1:0]           busySync;
  logic [1:0]           sdoSync;

  // busy and data come from the far end: synchronise
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      busySync <= 2'b00;
      sdoSync  <= 2'b00;
    end else begin
      busySync <= {busySync[0], link.busy};
      sdoSync  <= {sdoSync[0], link.serialLine};
    end
  end

  wire [BIT_CNT_W-1:0] nBits = (readBits == 5'd0) ? 5'd16 : readBits;
  // first low phase is doubled so the select reaches the far end first
  wire [31:0]          halfLen = (!sck_reg && bits_reg == '0)
                                 ? 32'(2 * SHIFT_HALF_CYCLES - 1)
                                 : 32'(SHIFT_HALF_CYCLES - 1);

  assign link.conversionTrigger      = cnv_reg;
  assign link.shiftClock             = sck_reg;
  assign link.chainStrap             = chainSel;
  assign link.readSelectOrChainInput = chainSel ? 1'b0
                                       : ~(state_reg == H_SHIFT);
  // not ready while a wake edge is still owed to a sleeping converter
  assign ready = (state_reg == H_IDLE) && !slept_reg;

  // sequencer: power-on wait, trigger, wait busy, shift, acquire
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg   <= H_POR;
      cnt_reg     <= '0;
      bits_reg    <= '0;
      sck_reg     <= 1'b0;
      cnv_reg     <= 1'b0;
      second_reg  <= 1'b0;
      slept_reg   <= 1'b0;
      resultValid <= 1'b0;
      resultData  <= '0;
    end else begin
      resultValid <= 1'b0;
      cnt_reg     <= cnt_reg + 1;
      case (state_reg)
        H_POR: if (cnt_reg >= 32'(PowerOnWait)) state_reg <= H_IDLE;
        H_IDLE: begin
          cnt_reg <= '0;
          if (slept_reg) begin
            // one shift edge wakes, then wait
            sck_reg   <= 1'b1;
            slept_reg <= 1'b0;
            state_reg <= H_WAKE;
          end else if (startReq || sleepReq) begin
            cnv_reg    <= 1'b1;
            second_reg <= sleepReq;
            state_reg  <= H_TRIG;
          end
        end
        H_TRIG: begin
          // sleep asks for a second edge inside the window
          if (second_reg && cnt_reg == 32'd1) cnv_reg <= 1'b0;
          if (second_reg && cnt_reg == 32'd2) cnv_reg <= 1'b1;
          // trigger pulse stays within glitch window
          if (cnt_reg >= 32'(TRIG_GLITCH_CYCLES - 1)) begin
            cnv_reg <= 1'b0;
            cnt_reg <= '0;
            if (second_reg) begin
              second_reg <= 1'b0;
              slept_reg  <= 1'b1;
              state_reg  <= H_ACQ;
            end else begin
              state_reg  <= H_WAIT;
            end
          end
        end
        H_WAIT: begin
          if (busySync[1]) begin
            cnt_reg <= 32'd5;
          end else if (cnt_reg > 32'd4) begin
            cnt_reg    <= '0;
            bits_reg   <= '0;
            resultData <= '0;
            state_reg  <= H_SHIFT;
          end
        end
        H_SHIFT: begin
          if (cnt_reg >= halfLen) begin
            cnt_reg <= '0;
            if (!sck_reg) begin
              resultData <= {resultData[30:0], sdoSync[1]};
              bits_reg   <= bits_reg + 1'b1;
              sck_reg    <= 1'b1;
            end else begin
              sck_reg <= 1'b0;
              if (bits_reg == nBits) begin
                resultValid <= 1'b1;
                state_reg   <= H_ACQ;
              end
            end
          end
        end
        H_ACQ: begin
          // acquisition time counted from entry to H_ACQ, restarted while busy is high
          if (busySync[1]) begin
            cnt_reg <= '0;
          end else if (cnt_reg >= 32'(ACQ_CYCLES)) begin
            cnt_reg   <= '0;
            state_reg <= H_IDLE;
          end
        end
        H_WAKE: begin
          // wake edge keeps the normal high phase; the wake delay is counted from the same start as the edge
          if (cnt_reg >= 32'(SHIFT_HALF_CYCLES - 1)) sck_reg <= 1'b0;
          if (cnt_reg >= 32'(WakeWait)) state_reg <= H_IDLE;
        end
        default: state_reg <= H_IDLE;
      endcase
    end
  end

endmodule : sacsr_host

// ==== core/sacsr_pkg.sv ====
// shared constants and types for the converter control and readout ends
package sacsr_pkg;
  localparam int CLK_PERIOD_NS       = 10;
  localparam int RESULT_BITS         = 16;
  localparam int CONV_MAX_NS         = 527;
  localparam int CONV_CYCLES         = CONV_MAX_NS / CLK_PERIOD_NS;
  localparam int TRIG_GLITCH_NS      = 40;
  localparam int TRIG_GLITCH_CYCLES  =
    (TRIG_GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACQ_MIN_NS          = 460;
  localparam int ACQ_CYCLES          =
    (ACQ_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int POR_WAIT_US         = 200;
  localparam int POR_WAIT_CYCLES     = POR_WAIT_US * 1000 / CLK_PERIOD_NS;
  localparam int WAKE_DELAY_US       = 200;
  localparam int WAKE_DELAY_CYCLES   = WAKE_DELAY_US * 1000 / CLK_PERIOD_NS;
  localparam int SHIFT_HALF_CYCLES   = 4;
  localparam int CNT_W               = 16;
  localparam int BIT_CNT_W           = 5;
  localparam logic [RESULT_BITS-1:0] RESULT_RESET = 16'h0000;

  typedef enum logic [1:0] {
    SACSR_IDLE, SACSR_CONV, SACSR_SLEEP
  } sacsr_dev_state_type;
endpackage : sacsr_pkg

// ==== core/sacsr_link_if.sv ====
// link between the converter end and the host end
`timescale 1ns/1ps
interface sacsr_link_if;
  logic conversionTrigger;
  logic shiftClock;
  logic chainStrap;
  logic readSelectOrChainInput;
  logic busy;
  logic serialOut;
  logic serialOutEnN;   // low while the converter drives serialOut
  wire  serialLine = serialOutEnN ? 1'b1 : serialOut;  // weak pull-up view

  modport dev (
    input  conversionTrigger, shiftClock, chainStrap,
           readSelectOrChainInput,
    output busy, serialOut, serialOutEnN
  );
  modport host (
    output conversionTrigger, shiftClock, chainStrap,
           readSelectOrChainInput,
    input  busy, serialLine
  );
endinterface : sacsr_link_if

// ==== core/sacsr_device.sv ====
// converter end: conversion timing, sleep and serial readout
`timescale 1ns/1ps
module sacsr_device
  import sacsr_pkg::*;
(
  // clock and reset
  input  wire logic                          clk,
  input  wire logic                          sys_rst,
  // link
  sacsr_link_if.dev                          link,
  // user side: result source and status
  input  wire logic [sacsr_pkg::RESULT_BITS-1:0] sampleValue,
  output logic                               corePowered,
  output logic                               sleeping,
  output logic [sacsr_pkg::RESULT_BITS-1:0]  lastResult
);
  import sacsr_pkg::*;

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [1:0] trigSync;
  logic [1:0] sckSync;
  logic [1:0] selSync;
  logic [1:0] strapSync;
  logic       trigPrev_reg;
  logic       sckPrev_reg;

  // two flip-flops per pin, then edge history
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      trigSync     <= 2'b00;
      sckSync      <= 2'b00;
      selSync      <= 2'b11;
      strapSync    <= 2'b00;
      trigPrev_reg <= 1'b0;
      sckPrev_reg  <= 1'b0;
    end else begin
      trigSync     <= {trigSync[0], link.conversionTrigger};
      sckSync      <= {sckSync[0], link.shiftClock};
      selSync      <= {selSync[0], link.readSelectOrChainInput};
      strapSync    <= {strapSync[0], link.chainStrap};
      trigPrev_reg <= trigSync[1];
      sckPrev_reg  <= sckSync[1];
    end
  end

  wire trigRise  = trigSync[1] & ~trigPrev_reg;
  wire sckRise   = sckSync[1] & ~sckPrev_reg;
  wire chainMode = strapSync[1];
  wire selLow    = ~selSync[1];
  wire chainIn   = selSync[1];

  // ****************************************
  // conversion control
  // ****************************************
  sacsr_dev_state_type               state_reg;
  sacsr_dev_state_type               state_next;
  logic [CNT_W-1:0]                  convCnt_reg;
  logic [1:0]                        trigCount_reg;
  logic [RESULT_BITS-1:0]            shift_reg;

  wire convDone = (state_reg == SACSR_CONV)
                  && (convCnt_reg == CNT_W'(CONV_CYCLES - 1));
  // a second trigger with no shift edge in between asks for sleep
  wire sleepReq = (trigCount_reg >= 2'd2);

  // next state decode
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      SACSR_IDLE:  if (trigRise) state_next = SACSR_CONV;
      SACSR_CONV: begin
        if (convDone) state_next = sleepReq ? SACSR_SLEEP : SACSR_IDLE;
      end
      SACSR_SLEEP: if (sckRise) state_next = SACSR_IDLE;
      default:     state_next = SACSR_IDLE;
    endcase
  end

  // state, conversion timer and sleep request count
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg     <= SACSR_IDLE;
      convCnt_reg   <= '0;
      trigCount_reg <= 2'd0;
    end else begin
      state_reg <= state_next;
      if (state_reg == SACSR_CONV) convCnt_reg <= convCnt_reg + 1'b1;
      else                         convCnt_reg <= '0;
      // trigger edge counted even if a shift edge lands with it
      if (trigRise && trigCount_reg != 2'd2)
        trigCount_reg <= trigCount_reg + 1'b1;
      else if (sckRise && !trigRise)
        trigCount_reg <= 2'd0;
      else if (convDone && sleepReq)
        trigCount_reg <= 2'd0;
    end
  end

  assign link.busy   = (state_reg == SACSR_CONV);
  assign corePowered = (state_reg == SACSR_CONV);
  assign sleeping    = (state_reg == SACSR_SLEEP);

  // ****************************************
  // serial readout
  // ****************************************
  // result load at busy fall, shift on each rising shift edge outside sleep
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      shift_reg  <= RESULT_RESET;
      lastResult <= RESULT_RESET;
    end else if (convDone) begin
      // top bit ready at busy fall
      shift_reg  <= sampleValue;
      lastResult <= sampleValue;
    end else if (sckRise && state_reg != SACSR_SLEEP) begin
      shift_reg <= {shift_reg[RESULT_BITS-2:0],
                    chainMode ? chainIn : 1'b0};
    end
  end

  // top bit held until first edge
  assign link.serialOut   = shift_reg[RESULT_BITS-1];
  assign link.serialOutEnN = ~(chainMode | selLow);

endmodule : sacsr_device

// ==== sim/sacsr_link_checker.sv ====
// concurrent checks on the link between converter and host ends
`timescale 1ns/1ps
module sacsr_link_checker (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // link signals
  input wire logic conversionTrigger,
  input wire logic shiftClock,
  input wire logic chainStrap,
  input wire logic readSelectOrChainInput,
  input wire logic busy,
  input wire logic serialOut,
  input wire logic serialOutEnN
);
  import sacsr_pkg::*;
  logic [7:0] busyCntReg;
  logic [7:0] busyCntNext;
  logic [7:0] idleCntReg;
  logic [7:0] idleCntNext;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // cycles spent busy, and idle cycles since busy fell (saturating)
  assign busyCntNext = busy ? busyCntReg + 8'h01 : 8'h00;
  assign idleCntNext = busy ? 8'h00 :
                       (idleCntReg == 8'hFF) ? 8'hFF : idleCntReg + 8'h01;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      busyCntReg <= 8'h00;
      idleCntReg <= 8'hFF;
    end else begin
      busyCntReg <= busyCntNext;
      idleCntReg <= idleCntNext;
    end
  end
  a_trig_starts_busy: assert property (
    $rose(conversionTrigger) && !busy |-> ##[1:5] busy)
    else $error("trigger edge did not start a conversion");
  a_busy_exact_length: assert property (
    $fell(busy) |-> busyCntReg == CONV_CYCLES)
    else $error("busy width differs from conversion time");
  a_busy_never_long: assert property (
    busyCntReg <= CONV_CYCLES)
    else $error("conversion ran past its maximum time");
  a_acq_gap_kept: assert property (
    $rose(conversionTrigger) && !busy |-> idleCntReg >= ACQ_CYCLES - 1)
    else $error("trigger came before acquisition time ran out");
  a_normal_released: assert property (
    (!chainStrap && readSelectOrChainInput)[*4] |-> serialOutEnN)
    else $error("serial output driven while not selected");
  a_normal_selected: assert property (
    (!chainStrap && !readSelectOrChainInput)[*4] |-> !serialOutEnN)
    else $error("selected device not driving serial output");
  a_chain_always_drives: assert property (
    chainStrap[*4] |-> !serialOutEnN)
    else $error("chain mode left serial output undriven");
  a_out_holds_idle: assert property (
    (!busy && !shiftClock && !conversionTrigger)[*5] |=> $stable(serialOut))
    else $error("serial output moved without a shift edge");
  a_shift_half_period: assert property (
    $rose(shiftClock) |-> shiftClock[*4] ##1 !shiftClock)
    else $error("shift clock high phase is not four cycles");
  a_trig_in_window: assert property (
    $changed(conversionTrigger) && busy |-> busyCntReg < TRIG_GLITCH_CYCLES)
    else $error("trigger moved late in a conversion");
  a_shift_not_in_conv: assert property (
    $rose(shiftClock) |-> !busy)
    else $error("shift clock edge during a conversion");
  c_conv_done: cover property ($fell(busy));
  c_chain_shift: cover property (chainStrap && $rose(shiftClock));
  c_double_trig: cover property (
    $rose(conversionTrigger) ##[1:8] $rose(conversionTrigger));
endmodule : sacsr_link_checker

// ==== sim/tb.sv ====
// self-checking bench joining the host end and the converter end
`timescale 1ns/1ps
module tb;
  import sacsr_pkg::*;
  // clock, reset and user side signals
  logic                   clk;
  logic                   sys_rst;
  logic [RESULT_BITS-1:0] sampleValue;
  logic                   startReq;
  logic                   sleepReq;
  logic                   chainSel;
  logic [4:0]             readBits;
  logic                   corePowered;
  logic                   sleeping;
  logic [RESULT_BITS-1:0] lastResult;
  logic                   ready;
  logic                   resultValid;
  logic [31:0]            resultData;
  int                     badCount;
  int                     nCompared;
  int                     cycles;
  sacsr_link_if link ();
  sacsr_device u_sacsr_device (.clk(clk), .sys_rst(sys_rst), .link(link),
    .sampleValue(sampleValue), .corePowered(corePowered),
    .sleeping(sleeping), .lastResult(lastResult));
  // short power-on and wake waits keep the run brief
  // host holds off triggers after reset
  sacsr_host #(.PowerOnWait(10), .WakeWait(10)) u_sacsr_host (.clk(clk),
    .sys_rst(sys_rst), .link(link), .startReq(startReq),
    .sleepReq(sleepReq), .chainSel(chainSel), .readBits(readBits),
    .ready(ready), .resultValid(resultValid), .resultData(resultData));
  sacsr_link_checker u_sacsr_link_checker (.clk(clk), .sys_rst(sys_rst),
    .conversionTrigger(link.conversionTrigger),
    .shiftClock(link.shiftClock), .chainStrap(link.chainStrap),
    .readSelectOrChainInput(link.readSelectOrChainInput),
    .busy(link.busy), .serialOut(link.serialOut),
    .serialOutEnN(link.serialOutEnN));
  // 100 MHz clock
  always #5 clk = ~clk;
  // compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    nCompared++;
    if (seen !== exp) begin
      badCount++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic endOfTest();
    if (badCount == 0 && nCompared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : endOfTest
  // select a status flag to wait on
  function automatic logic pick(input int which);
    case (which)
      0: return ready;
      1: return link.busy;
      2: return resultValid;
      default: return sleeping;
    endcase
  endfunction : pick
  // bounded wait, sampled at falling edges where outputs are settled
  task automatic waitFor(input int which, input logic level);
    int n;
    n = 0;
    while (pick(which) !== level && n < 2000) begin
      @(negedge clk);
      n++;
    end
    if (n == 2000) begin
      badCount++;
      $display("wrong value at %0t: flag %0d never came", $time, which);
    end
  endtask : waitFor
  // one conversion and readout through the host
  task automatic convert(input logic [15:0] value, input logic [4:0] bits,
                         input logic [31:0] exp);
    @(negedge clk);
    sampleValue = value;
    readBits    = bits;
    waitFor(0, 1'b1);
    startReq = 1'b1;
    @(negedge clk);
    startReq = 1'b0;
    waitFor(1, 1'b1);
    check({31'h0, corePowered}, 32'h0000_0001);
    waitFor(2, 1'b1);
    check(resultData, exp);
    check({16'h0000, lastResult}, {16'h0000, value});
    check({31'h0, corePowered}, 32'h0000_0000);
  endtask : convert
  // cycle ceiling against a hang
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      badCount++;
      endOfTest();
    end
  end
  // main sequence
  initial begin
    clk         = 1'b0;
    sys_rst     = 1'b1;
    sampleValue = 16'h0000;
    startReq    = 1'b0;
    sleepReq    = 1'b0;
    chainSel    = 1'b0;
    readBits    = 5'h00;
    badCount    = 0;
    nCompared   = 0;
    cycles      = 0;
    repeat (8) @(negedge clk);
    sys_rst = 1'b0;
    check({16'h0000, lastResult}, {16'h0000, RESULT_RESET});
    check({31'h0, link.busy}, 32'h0000_0000);
    convert(16'hA5C3, 5'h00, 32'h0000_A5C3);
    convert(16'h8001, 5'h08, 32'h0000_0080);
    convert(16'h0001, 5'h00, 32'h0000_0001);
    // sleep request, then the host's own wake edge before the next readout
    waitFor(0, 1'b1);
    sleepReq = 1'b1;
    @(negedge clk);
    sleepReq = 1'b0;
    waitFor(3, 1'b1);
    check({31'h0, sleeping}, 32'h0000_0001);
    convert(16'h5A3C, 5'h00, 32'h0000_5A3C);
    check({31'h0, sleeping}, 32'h0000_0000);
    // chain mode: own result leads the shifted stream
    chainSel = 1'b1;
    convert(16'h3C5A, 5'h00, 32'h0000_3C5A);
    convert(16'hC003, 5'h04, 32'h0000_000C);
    convert(16'hC003, 5'h14, 32'h000C_0030);
    endOfTest();
  end
endmodule : tb
